// *** core/dbs_pkg.sv ***
// constants for the hardware status word block
// assumes a 32-bit avalon-mm slave with word addressing in bytes
package dbs_pkg;
	// ==========================================
	// register map
	localparam logic [7:0] DBS_STATUS_OFS = 8'h18;
	localparam logic [7:0] DBS_CLR_DAQ_OFS = 8'h20;
	localparam logic [7:0] DBS_CLR_TCA_OFS = 8'h24;
	localparam logic [7:0] DBS_CLR_TCB_OFS = 8'h28;
	localparam logic [7:0] DBS_CLR_TMR_OFS = 8'h2C;
	localparam logic [7:0] DBS_CLR_DAC_OFS = 8'h30;
	localparam logic [7:0] DBS_MODE_OFS = 8'h34;
	localparam logic [7:0] DBS_IRQ_OFS = 8'h38;
	// ==========================================
	// status word fields
	localparam int DBS_B_ADC_NE = 12;
	localparam int DBS_B_ADC_HALF = 13;
	localparam int DBS_B_TCA = 11;
	localparam int DBS_B_TCB = 10;
	localparam int DBS_B_OVF = 9;
	localparam int DBS_B_OVR = 8;
	localparam int DBS_B_TMR = 7;
	localparam int DBS_B_DACDONE = 6;
	localparam int DBS_B_DAC_FULL = 5;
	localparam int DBS_B_DAC_HALF = 4;
	localparam int DBS_B_DAC_EMPTY = 3;
	localparam int DBS_B_ROM_DATA = 2;
	localparam int DBS_B_ROM_DESEL = 1;
	localparam int DBS_B_CFG = 0;
	// ==========================================
	// mode register fields and resets
	localparam int DBS_M_XFER_LO = 0;
	localparam int DBS_M_IRQ_EN = 2;
	localparam logic [1:0] DBS_XFER_PIO = 2'h0;
	localparam logic [1:0] DBS_XFER_IRQ = 2'h1;
	localparam logic [1:0] DBS_XFER_DMA = 2'h2;
	localparam logic [2:0] DBS_MODE_RST = 3'h0;
	localparam int DBS_ADC_HALF_CNT = 256;
	localparam int DBS_ADC_DEPTH = 512;
	localparam int DBS_DAC_DEPTH = 2048;
endpackage

// *** core/dbs_status.sv ***
// status word, clear strobes and request logic for the daq board
// assumes fifo level counts and events come from same-clock logic;
// the timer trigger and eeprom lines are pins and are synchronised here
// Behaviour
// - bit 12 high while adc fifo holds data; no conversion request when empty
// - channel a dma done flag sets on finish, clears on its strobe
// - channel b dma done flag sets on finish, clears on its strobe
// - overflow bit 9 sets when a conversion completes with fifo full
// - overflow during acquisition stops the acquisition at once
// - overrun bit 8 sets when conversion starts while one is busy
// - overrun during acquisition stops the acquisition at once
// - overflow and overrun clear only by the acquisition clear strobe
// - timer request bit 7 sets when dac fifo can accept, or on a trigger pulse in irq mode
// - timer request raises irq or dma per mode; dma mode clears on dac write
// - dac done bit 6 low while sequence runs, set at sequence end
// - dac done interrupt cleared by timer clear or dac clear strobe
// - bit 5 low when dac fifo full; requests only while below half
// - bit 4 low when dac fifo at least half; requests below half outside pio mode
// - bit 3 low when dac fifo empty, high with points left
// - bit 2 shows eeprom serial data bit
// - bit 1 shows actual eeprom chip select pin state
// - bit 0 low when channel config memory empty, high otherwise
// - status word is 16 bits read only at offset 0x18
// - adc half flag low with at least 256 conversions waiting
//
// Implementation choices: the Avalon-MM slave port and the register addresses.
module dbs_status
	import dbs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [9:0] adc_fifo_level,
	input wire logic adc_conv_start,
	input wire logic adc_conv_done,
	input wire logic adc_busy,
	input wire logic daq_running,
	output logic daq_abort,
	input wire logic dma_chan_a_tc,
	input wire logic dma_chan_b_tc,
	input wire logic [11:0] dac_fifo_level,
	input wire logic dac_write,
	input wire logic dac_seq_running,
	input wire logic dac_seq_end,
	input wire logic timer_trigger_n,
	input wire logic cal_rom_serial_out,
	input wire logic cal_rom_select,
	input wire logic chan_cfg_mem_not_empty,
	output logic adc_req,
	output logic timer_irq,
	output logic timer_dma_req,
	output logic dac_fifo_req,
	output logic dac_done_irq
);
	import dbs_pkg::*;

	// ==========================================
	// pin synchronisers
	logic trig_s1_r, trig_s2_r, trig_s3_r;
	logic rom_d1_r, rom_d2_r, rom_cs1_r, rom_cs2_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_s1_r <= 1'b1;
			trig_s2_r <= 1'b1;
			trig_s3_r <= 1'b1;
			rom_d1_r <= 1'b0;
			rom_d2_r <= 1'b0;
			rom_cs1_r <= 1'b0;
			rom_cs2_r <= 1'b0;
		end else begin
			trig_s1_r <= timer_trigger_n;
			trig_s2_r <= trig_s1_r;
			trig_s3_r <= trig_s2_r;
			rom_d1_r <= cal_rom_serial_out;
			rom_d2_r <= rom_d1_r;
			rom_cs1_r <= cal_rom_select;
			rom_cs2_r <= rom_cs1_r;
		end
	end
	// falling edge of the active-low trigger, seen only past stage two
	logic trig_pulse;
	assign trig_pulse = trig_s3_r & ~trig_s2_r;

	// ==========================================
	// bus decode
	logic wr_hit, rd_status;
	logic clr_daq, clr_tca, clr_tcb, clr_tmr, clr_dac;
	assign wr_hit = avs_write & (avs_byteenable != 4'h0);
	assign clr_daq = wr_hit & (avs_address == DBS_CLR_DAQ_OFS);
	assign clr_tca = wr_hit & (avs_address == DBS_CLR_TCA_OFS);
	assign clr_tcb = wr_hit & (avs_address == DBS_CLR_TCB_OFS);
	assign clr_tmr = wr_hit & (avs_address == DBS_CLR_TMR_OFS);
	assign clr_dac = wr_hit & (avs_address == DBS_CLR_DAC_OFS);
	// reads take one wait state so the registered data stands at the accept edge
	logic rd_ack_r, rd_take;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_ack_r <= 1'b0;
		end else begin
			rd_ack_r <= avs_read & ~rd_ack_r;
		end
	end
	assign rd_take = avs_read & ~rd_ack_r;
	assign rd_status = rd_take & (avs_address == DBS_STATUS_OFS);
	// writes finish at once; reads wait one cycle
	assign avs_waitrequest = rd_take;

	logic [2:0] mode_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_r <= DBS_MODE_RST;
		end else if (avs_write && avs_address == DBS_MODE_OFS && avs_byteenable[0]) begin
			mode_r <= avs_writedata[2:0];
		end
	end
	logic [1:0] xfer_mode;
	logic irq_en;
	assign xfer_mode = mode_r[DBS_M_XFER_LO +: 2];
	assign irq_en = mode_r[DBS_M_IRQ_EN];

	// ==========================================
	// sticky flags; set always beats clear
	logic tca_r, tcb_r, ovf_r, ovr_r, tmr_r, dac_irq_r;
	logic adc_full, ovf_evt, ovr_evt, dac_can_take;
	assign adc_full = (adc_fifo_level >= 10'(DBS_ADC_DEPTH));
	assign ovf_evt = adc_conv_done & adc_full;
	assign ovr_evt = adc_conv_start & adc_busy;
	assign dac_can_take = (dac_fifo_level < 12'(DBS_DAC_DEPTH));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tca_r <= 1'b0;
		end else if (dma_chan_a_tc) begin
			tca_r <= 1'b1;
		end else if (clr_tca) begin
			tca_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tcb_r <= 1'b0;
		end else if (dma_chan_b_tc) begin
			tcb_r <= 1'b1;
		end else if (clr_tcb) begin
			tcb_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ovf_r <= 1'b0;
			ovr_r <= 1'b0;
		end else begin
			if (ovf_evt) begin
				ovf_r <= 1'b1;
			end else if (clr_daq) begin
				ovf_r <= 1'b0;
			end
			if (ovr_evt) begin
				ovr_r <= 1'b1;
			end else if (clr_daq) begin
				ovr_r <= 1'b0;
			end
		end
	end

	// abort pulse in the very cycle of the error event
	assign daq_abort = daq_running & (ovf_evt | ovr_evt);

	// host strobe is the only clear outside dma mode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tmr_r <= 1'b0;
		end else if (dac_can_take || (xfer_mode == DBS_XFER_IRQ && trig_pulse)) begin
			tmr_r <= 1'b1;
		end else if (xfer_mode == DBS_XFER_DMA && dac_write) begin
			tmr_r <= 1'b0;
		end else if (clr_tmr) begin
			tmr_r <= 1'b0;
		end
	end
	assign timer_irq = tmr_r & (xfer_mode == DBS_XFER_IRQ);
	assign timer_dma_req = tmr_r & (xfer_mode == DBS_XFER_DMA);

	// dac done: end of sequence sets, running holds low
	logic dac_done_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dac_done_r <= 1'b0;
		end else if (dac_seq_end) begin
			dac_done_r <= 1'b1;
		end else if (dac_seq_running) begin
			dac_done_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dac_irq_r <= 1'b0;
		end else if (dac_seq_end && irq_en) begin
			dac_irq_r <= 1'b1;
		end else if (clr_tmr || clr_dac) begin
			dac_irq_r <= 1'b0;
		end
	end
	assign dac_done_irq = dac_irq_r;

	// ==========================================
	// level flags
	logic adc_ne, adc_half_n, dac_full_n, dac_half_n, dac_empty_n;
	assign adc_ne = (adc_fifo_level != 10'h000);
	assign adc_half_n = (adc_fifo_level < 10'(DBS_ADC_HALF_CNT));
	assign dac_full_n = dac_can_take;
	assign dac_half_n = (dac_fifo_level < 12'(DBS_DAC_DEPTH / 2));
	assign dac_empty_n = (dac_fifo_level != 12'h000);
	// the host keeps draining; the request drops only at empty
	assign adc_req = adc_ne;
	assign dac_fifo_req = (xfer_mode != DBS_XFER_PIO) & dac_full_n & dac_half_n;

	logic [15:0] status_word;
	always_comb begin
		status_word = 16'h0000;
		status_word[DBS_B_ADC_HALF] = adc_half_n;
		status_word[DBS_B_ADC_NE] = adc_ne;
		status_word[DBS_B_TCA] = tca_r;
		status_word[DBS_B_TCB] = tcb_r;
		status_word[DBS_B_OVF] = ovf_r;
		status_word[DBS_B_OVR] = ovr_r;
		status_word[DBS_B_TMR] = tmr_r;
		status_word[DBS_B_DACDONE] = dac_done_r;
		status_word[DBS_B_DAC_FULL] = dac_full_n;
		status_word[DBS_B_DAC_HALF] = dac_half_n;
		status_word[DBS_B_DAC_EMPTY] = dac_empty_n;
		status_word[DBS_B_ROM_DATA] = rom_d2_r;
		status_word[DBS_B_ROM_DESEL] = rom_cs2_r;
		status_word[DBS_B_CFG] = chan_cfg_mem_not_empty;
	end

	// ==========================================
	// read data; no read touches any flag
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (rd_status) begin
			avs_readdata <= {16'h0000, status_word};
		end else if (rd_take && avs_address == DBS_MODE_OFS) begin
			avs_readdata <= {29'h0000_0000, mode_r};
		end else if (rd_take && avs_address == DBS_IRQ_OFS) begin
			avs_readdata <= {27'h0000_0000, dac_irq_r, timer_dma_req, timer_irq,
				dac_fifo_req, adc_req};
		end else if (rd_take) begin
			avs_readdata <= 32'h0000_0000;
		end
	end
endmodule

// *** sim/dbs_status_sva.sv ***
// checker for the status word block: read-back fields and request pins
// assumes it is bound into dbs_status and shares its port names
module dbs_status_sva
	import dbs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [9:0] adc_fifo_level,
	input wire logic adc_conv_start,
	input wire logic adc_conv_done,
	input wire logic adc_busy,
	input wire logic daq_running,
	input wire logic daq_abort,
	input wire logic [11:0] dac_fifo_level,
	input wire logic chan_cfg_mem_not_empty,
	input wire logic adc_req,
	input wire logic dac_fifo_req
);
	// ==========
	// inputs seen at the read edge; readdata lands a cycle later
	logic rd_r;
	logic cfg_r;
	logic [9:0] al_r;
	logic [11:0] dl_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rd_r <= 1'b0;
		else
			rd_r <= avs_read && avs_waitrequest && avs_address == DBS_STATUS_OFS;
	end
	always_ff @(posedge clk) begin
		cfg_r <= chan_cfg_mem_not_empty;
		al_r <= adc_fifo_level;
		dl_r <= dac_fifo_level;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ==========
	// properties
	property p_ovf;
		daq_running && adc_conv_done && adc_fifo_level >= 10'd512 |-> daq_abort;
	endproperty
	a_ovf: assert property (p_ovf) else $error("no abort on overflow");
	property p_ovr;
		daq_running && adc_conv_start && adc_busy |-> daq_abort;
	endproperty
	a_ovr: assert property (p_ovr) else $error("no abort on overrun");
	property p_hi; rd_r |-> avs_readdata[31:16] == 16'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper half not zero");
	property p_adc;
		rd_r |-> avs_readdata[13:12] == {al_r < 10'd256, al_r != 10'd0};
	endproperty
	a_adc: assert property (p_adc) else $error("adc flags wrong");
	property p_dac;
		rd_r |-> avs_readdata[5:3] == {dl_r < 12'd2048, dl_r < 12'd1024, dl_r != 12'd0};
	endproperty
	a_dac: assert property (p_dac) else $error("dac flags wrong");
	property p_cfg; rd_r |-> avs_readdata[0] == cfg_r; endproperty
	a_cfg: assert property (p_cfg) else $error("cfg flag wrong");
	property p_areq; adc_fifo_level == 10'd0 |-> !adc_req; endproperty
	a_areq: assert property (p_areq) else $error("adc request when empty");
	property p_dreq; dac_fifo_level >= 12'd1024 |-> !dac_fifo_req; endproperty
	a_dreq: assert property (p_dreq) else $error("dac request at half");
endmodule

bind dbs_status dbs_status_sva dbs_status_sva_inst (.*);

// *** sim/dbs_host.sv ***
// host side bus master for the status block
// assumes waitrequest answers on clk; read data taken at the accept edge
module dbs_host (
	input wire logic clk,
	output logic [7:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	output logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	initial begin
		avs_address = 8'hFF;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
	end
	task automatic xfer(input logic [7:0] a, input logic [31:0] d, input logic w,
		output logic [31:0] q);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= 4'hF;
		avs_read <= !w;
		avs_write <= w;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// idle lines flip so a stale value never looks meaningful
		avs_address <= ~a;
		avs_writedata <= ~d;
	endtask
endmodule

// *** sim/dbs_status_tb_top.sv ***
// bench for the status word block against an integer model
// assumes the host model masters the bus, the bench drives the pins
module dbs_status_tb_top
	import dbs_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n, avs_read, avs_write, avs_waitrequest;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [3:0] avs_byteenable;
	logic [9:0] adc_fifo_level;
	logic [11:0] dac_fifo_level;
	logic adc_conv_start, adc_conv_done, adc_busy, daq_running, daq_abort;
	logic dma_chan_a_tc, dma_chan_b_tc, dac_write, dac_seq_running, dac_seq_end;
	logic timer_trigger_n, cal_rom_serial_out, cal_rom_select, chan_cfg_mem_not_empty;
	logic adc_req, timer_irq, timer_dma_req, dac_fifo_req, dac_done_irq;
	logic [7:0] clr [2] = '{DBS_CLR_DAC_OFS, DBS_CLR_TMR_OFS};
	int tca, tcb, ovf, ovr, tmr, dn, n_tests, n_mismatch;
	integer seed = 32'h25d0;
	dbs_status dbs_status_inst (.*);
	dbs_host dbs_host_inst (.*);
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// ==========
	// model and checks
	function automatic logic [15:0] exp_st();
		return {2'b0, adc_fifo_level < 10'd256, adc_fifo_level != 10'd0, tca[0], tcb[0],
			ovf[0], ovr[0], tmr[0], dn[0], dac_fifo_level < 12'd2048,
			dac_fifo_level < 12'd1024, dac_fifo_level != 12'd0, cal_rom_serial_out,
			cal_rom_select, chan_cfg_mem_not_empty};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		dbs_host_inst.xfer(a, d, 1'b1, r);
		// let the write settle before anything looks at its effect
		@(posedge clk);
	endtask
	task automatic rd_st();
		logic [31:0] r;
		logic [15:0] e;
		dbs_host_inst.xfer(DBS_STATUS_OFS, 32'h0, 1'b0, r);
		e = exp_st();
		chk("status", {18'h0, e[13:0]}, {2'b0, r[31:16], r[13:0]});
	endtask
	task automatic finish_test();
		if (n_mismatch == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (6000) @(posedge clk);
		n_mismatch++;
		finish_test();
	end
	// ==========
	// scenarios
	initial begin
		{adc_conv_start, adc_conv_done, adc_busy, daq_running, dma_chan_a_tc} = 5'h0;
		{dma_chan_b_tc, dac_write, dac_seq_running, dac_seq_end} = 4'h0;
		{cal_rom_serial_out, cal_rom_select, chan_cfg_mem_not_empty} = 3'h0;
		adc_fifo_level = 10'h0;
		dac_fifo_level = 12'h0;
		timer_trigger_n = 1'b1;
		rst_n = 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		tmr = 1;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			adc_fifo_level <= i == 0 ? 10'h100 : i == 1 ? 10'h0FF : 10'($unsigned($random(seed)) % 513);
			dac_fifo_level <= i == 0 ? 12'h400 : i == 1 ? 12'h800 : 12'($unsigned($random(seed)) % 2049);
			{cal_rom_serial_out, cal_rom_select, chan_cfg_mem_not_empty} <= 3'($random(seed));
			repeat (3) @(posedge clk);
			rd_st();
		end
		dbs_host_inst.xfer(8'h3C, 32'h0, 1'b0, q);
		chk("unmapped", 32'h0, q);
		@(posedge clk);
		{dma_chan_a_tc, dma_chan_b_tc} <= 2'h3;
		@(posedge clk);
		{dma_chan_a_tc, dma_chan_b_tc} <= 2'h0;
		{tca, tcb} = {1, 1};
		wr(DBS_STATUS_OFS, 32'hFFFF);
		rd_st();
		rd_st();
		wr(DBS_CLR_TCA_OFS, 32'h1);
		tca = 0;
		rd_st();
		wr(DBS_CLR_TCB_OFS, 32'h1);
		tcb = 0;
		rd_st();
		@(posedge clk);
		{daq_running, adc_conv_done} <= 2'h3;
		adc_fifo_level <= 10'h200;
		@(posedge clk);
		chk("abort", 1, daq_abort);
		adc_conv_done <= 1'b0;
		{adc_busy, adc_conv_start} <= 2'h3;
		@(posedge clk);
		chk("abort", 1, daq_abort);
		{daq_running, adc_busy, adc_conv_start} <= 3'h0;
		{ovf, ovr} = {1, 1};
		rd_st();
		wr(DBS_CLR_TCA_OFS, 32'h1);
		rd_st();
		wr(DBS_CLR_DAQ_OFS, 32'h1);
		{ovf, ovr} = {0, 0};
		rd_st();
		dac_fifo_level <= 12'h800;
		wr(DBS_CLR_TMR_OFS, 32'h1);
		tmr = 0;
		rd_st();
		wr(DBS_MODE_OFS, 32'h5);
		timer_trigger_n <= 1'b0;
		repeat (2) @(posedge clk);
		timer_trigger_n <= 1'b1;
		repeat (5) @(posedge clk);
		tmr = 1;
		rd_st();
		chk("timer_irq", 1, timer_irq);
		wr(DBS_MODE_OFS, 32'h2);
		chk("timer_dma", 1, timer_dma_req);
		chk("timer_irq", 0, timer_irq);
		chk("dac_req", 0, dac_fifo_req);
		dac_write <= 1'b1;
		@(posedge clk);
		dac_write <= 1'b0;
		tmr = 0;
		rd_st();
		dac_fifo_level <= 12'h3FF;
		@(posedge clk);
		tmr = 1;
		chk("dac_req", 1, dac_fifo_req);
		wr(DBS_MODE_OFS, 32'h5);
		foreach (clr[i]) begin
			dac_seq_end <= 1'b1;
			@(posedge clk);
			dac_seq_end <= 1'b0;
			dn = 1;
			rd_st();
			chk("done_irq", 1, dac_done_irq);
			wr(clr[i], 32'h1);
			chk("done_irq", 0, dac_done_irq);
		end
		adc_fifo_level <= 10'h000;
		dac_fifo_level <= 12'h000;
		cal_rom_select <= 1'b0;
		repeat (3) @(posedge clk);
		chk("adc_req", 0, adc_req);
		rd_st();
		dac_seq_running <= 1'b1;
		dn = 0;
		rd_st();
		finish_test();
	end
endmodule
